// >>> verilog/tof_status_pkg.sv
package tof_status_pkg;
    // ------------------------------------------------------------
    // read codes of the registers in this bank
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_PULSE_RATIOS = 8'hC4;
    localparam logic [7:0] ADDR_HIT1_INT = 8'hC5;
    localparam logic [7:0] ADDR_HIT1_FRAC = 8'hC6;
    localparam logic [7:0] ADDR_EVENT_STATUS = 8'hFE;

    // ------------------------------------------------------------
    // event status bit positions
    // ------------------------------------------------------------
    localparam int BIT_WAIT_EXPIRED = 15;
    localparam int BIT_FLIGHT_DONE = 12;
    localparam int BIT_THERMAL_DONE = 11;
    localparam int BIT_TRIM_DONE = 6;
    localparam int BIT_SETUP_DONE = 3;
    localparam int BIT_POWER_UP = 2;

    // ------------------------------------------------------------
    // reset values and limits
    // ------------------------------------------------------------
    localparam logic [15:0] RESET_WORD = 16'h0000;
    localparam logic [15:0] HIT_INT_MAX = 16'h7FFF;
    localparam logic [7:0] RATIO_MAX = 8'hFF;
    localparam int RATIO_FRAC_BITS = 7;
    // reset settle time before the power-up flag is raised
    localparam int POWER_UP_NS = 100;
    localparam int CLK_PERIOD_NS = 5;
    localparam int POWER_UP_CYCLES = (POWER_UP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : tof_status_pkg

// >>> verilog/tof_status_regs.sv
// How it works
// - bit 15 set on any timeout of pulse widths, hits or temperature
// - bit 12 set when an upstream, downstream or delta flight command finishes
// - bit 11 set when a temperature command finishes
// - bit 6 set when a calibrate finishes, only if host issued it
// - bit 3 set when an initialize command finishes
// - bit 2 set after power-up; serial port silent until then
// - result registers are read-only to the host
// - result registers hold zero after reset
// - ratio upper byte is first over second width, 1.7 fixed point
// - ratio lower byte is second width over ideal width, same format
// - ideal width is half the launch period
// - each ratio saturates at 1.9921875
// - integer register holds whole reference periods, 15 bits
// - integer count limited to 7FFF, bit 15 stays zero
// - fraction register holds sub-period remainder, 16 bits
module tof_status_regs (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic spi_clk,
    input wire logic spi_csn,
    input wire logic spi_mosi,
    output logic spi_miso,
    output logic spi_miso_oen,
    input wire logic evt_wait_expired,
    input wire logic evt_flight_done,
    input wire logic evt_thermal_done,
    input wire logic evt_trim_done,
    input wire logic evt_trim_manual,
    input wire logic evt_setup_done,
    input wire logic result_valid,
    input wire logic [15:0] width_first,
    input wire logic [15:0] width_second,
    input wire logic [15:0] launch_period,
    input wire logic [31:0] hit_time,
    output logic port_ready
);
    // ------------------------------------------------------------
    // core-side state
    // ------------------------------------------------------------
    logic [15:0] event_status_word;
    logic [15:0] upstream_pulse_ratios;
    logic [15:0] upstream_first_hit_integer;
    logic [15:0] upstream_first_hit_fraction;
    logic [7:0] pu_cnt;
    logic powered;
    logic [15:0] next_set;
    logic [7:0] next_ratio_hi;
    logic [7:0] next_ratio_lo;
    logic [15:0] ideal_width;

    // ------------------------------------------------------------
    // link-side state (spi_clk domain)
    // ------------------------------------------------------------
    logic [2:0] bit_cnt;
    logic [7:0] cmd_shift;
    logic [15:0] out_shift;
    logic [4:0] out_cnt;
    logic in_data;
    logic rd_done_lvl;
    logic [7:0] rd_code;
    logic [1:0] rdy_sync;
    logic [15:0] snap_word;
    logic snap_ok;
    logic [15:0] word_hold;
    logic [15:0] load_word;
    logic load_now;

    // ------------------------------------------------------------
    // crossings: ready level to link, read-done level to core
    // ------------------------------------------------------------
    logic [2:0] done_sync;
    logic rd_done_pulse;
    logic [7:0] code_core;
    // the done level idles low and the flops reset low, so no false edge follows reset
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            done_sync <= 3'h0;
        end else begin
            done_sync <= {done_sync[1:0], rd_done_lvl};
        end
    end
    assign rd_done_pulse = done_sync[1] & ~done_sync[2];
    // code and shown word stand from the code's last bit until the frame ends,
    // many core cycles after the done edge is seen, so no handshake is needed
    assign code_core = rd_code;

    // power-up counter; port held inactive until the flag exists
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            pu_cnt <= 8'h00;
            powered <= 1'b0;
            port_ready <= 1'b0;
        end else begin
            if (!powered && pu_cnt == 8'(tof_status_pkg::POWER_UP_CYCLES - 1)) begin
                powered <= 1'b1;
            end
            if (!powered) begin
                pu_cnt <= pu_cnt + 8'h01;
            end
            port_ready <= powered;
        end
    end

    // event set vector
    always_comb begin
        next_set = 16'h0000;
        next_set[tof_status_pkg::BIT_WAIT_EXPIRED] = evt_wait_expired;
        next_set[tof_status_pkg::BIT_FLIGHT_DONE] = evt_flight_done;
        next_set[tof_status_pkg::BIT_THERMAL_DONE] = evt_thermal_done;
        next_set[tof_status_pkg::BIT_TRIM_DONE] = evt_trim_done & evt_trim_manual;
        next_set[tof_status_pkg::BIT_SETUP_DONE] = evt_setup_done;
        next_set[tof_status_pkg::BIT_POWER_UP] = !powered && pu_cnt ==
            8'(tof_status_pkg::POWER_UP_CYCLES - 1);
    end

    // sticky flags; a set in the clearing cycle wins
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            event_status_word <= tof_status_pkg::RESET_WORD;
        end else if (rd_done_pulse && code_core == tof_status_pkg::ADDR_EVENT_STATUS) begin
            // only flags the host was shown are dropped; later ones wait for the next read
            event_status_word <= (event_status_word & ~word_hold) | next_set;
        end else begin
            event_status_word <= event_status_word | next_set;
        end
    end

    // ratio computation, 1.7 fixed point with saturation
    function automatic logic [7:0] ratio_of(input logic [15:0] num, input logic [15:0] den);
        logic [22:0] q;
        q = 23'h0;
        if (den == 16'h0000) begin
            ratio_of = tof_status_pkg::RATIO_MAX;
        end else begin
            q = ({7'h00, num} << tof_status_pkg::RATIO_FRAC_BITS) / {7'h00, den};
            ratio_of = (q > 23'(tof_status_pkg::RATIO_MAX)) ? tof_status_pkg::RATIO_MAX
                : q[7:0];
        end
    endfunction : ratio_of

    always_comb begin
        ideal_width = {1'b0, launch_period[15:1]};
        next_ratio_hi = ratio_of(width_first, width_second);
        next_ratio_lo = ratio_of(width_second, ideal_width);
    end

    // results load only from the engine, never from the host
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            upstream_pulse_ratios <= tof_status_pkg::RESET_WORD;
            upstream_first_hit_integer <= tof_status_pkg::RESET_WORD;
            upstream_first_hit_fraction <= tof_status_pkg::RESET_WORD;
        end else if (result_valid) begin
            upstream_pulse_ratios <= {next_ratio_hi, next_ratio_lo};
            upstream_first_hit_integer <= (hit_time[31:16] > tof_status_pkg::HIT_INT_MAX)
                ? tof_status_pkg::HIT_INT_MAX : hit_time[31:16];
            upstream_first_hit_fraction <= hit_time[15:0];
        end
    end

    // ------------------------------------------------------------
    // serial link: 8-bit read code in, 16-bit word out, msb first
    // ------------------------------------------------------------
    always_ff @(posedge spi_clk or posedge spi_csn) begin
        if (spi_csn) begin
            rdy_sync <= 2'h0;
        end else begin
            rdy_sync <= {rdy_sync[0], port_ready};
        end
    end

    // shift in the read code on rising edges
    always_ff @(posedge spi_clk or posedge spi_csn) begin
        if (spi_csn) begin
            bit_cnt <= 3'h0;
            cmd_shift <= 8'h00;
            in_data <= 1'b0;
        end else if (!in_data) begin
            cmd_shift <= {cmd_shift[6:0], spi_mosi};
            bit_cnt <= bit_cnt + 3'h1;
            if (bit_cnt == 3'h7) begin
                in_data <= 1'b1;
            end
        end
    end

    // word snapshot at the code's last bit; core words are quasi-static here,
    // a limitation accepted to keep the crossing small
    always_comb begin
        case ({cmd_shift[6:0], spi_mosi})
            tof_status_pkg::ADDR_PULSE_RATIOS: snap_word = upstream_pulse_ratios;
            tof_status_pkg::ADDR_HIT1_INT: snap_word = upstream_first_hit_integer;
            tof_status_pkg::ADDR_HIT1_FRAC: snap_word = upstream_first_hit_fraction;
            tof_status_pkg::ADDR_EVENT_STATUS: snap_word = event_status_word;
            default: snap_word = 16'h0000;
        endcase
        snap_ok = rdy_sync[1];
    end

    // output shifter on falling edges; counts bits sent
    always_ff @(negedge spi_clk or posedge spi_csn) begin
        if (spi_csn) begin
            out_shift <= 16'h0000;
            out_cnt <= 5'h00;
            spi_miso <= 1'b0;
            spi_miso_oen <= 1'b1;
        end else if (in_data && snap_ok) begin
            spi_miso_oen <= 1'b0;
            out_cnt <= (out_cnt == 5'h10) ? out_cnt : out_cnt + 5'h01;
            // first falling edge takes the shown word, later ones shift it
            if (out_cnt == 5'h00) begin
                spi_miso <= word_hold[15];
                out_shift <= {word_hold[14:0], 1'b0};
            end else begin
                spi_miso <= out_shift[15];
                out_shift <= {out_shift[14:0], 1'b0};
            end
        end
    end

    // capture the read code on the rising edge that completes it
    always_ff @(posedge spi_clk or posedge spi_csn) begin
        if (spi_csn) begin
            rd_code <= 8'h00;
        end else if (!in_data && bit_cnt == 3'h7) begin
            rd_code <= {cmd_shift[6:0], spi_mosi};
        end
    end

    // done level once the last bit has been sampled; the frame end drops it,
    // so a cut frame never clears anything
    always_ff @(posedge spi_clk or posedge spi_csn) begin
        if (spi_csn) begin
            rd_done_lvl <= 1'b0;
        end else if (in_data && out_cnt == 5'h10 && snap_ok) begin
            rd_done_lvl <= 1'b1;
        end
    end

    // shown word, taken at the rising edge that completes the code
    assign load_now = !in_data && bit_cnt == 3'h7;
    assign load_word = snap_word;
    always_ff @(posedge spi_clk or posedge spi_csn) begin
        if (spi_csn) begin
            word_hold <= 16'h0000;
        end else if (load_now) begin
            word_hold <= load_word;
        end
    end

    // ------------------------------------------------------------
    // checks on the core side
    // ------------------------------------------------------------
    // an engine event must be visible one cycle later, even in a clearing cycle
    a_flag_set_wins: assert property (
        @(posedge core_clk) disable iff (!rstn)
        next_set != 16'h0000 |=> (event_status_word & $past(next_set)) == $past(next_set)
    ) else $error("event flag lost in the cycle it was raised");

    // a finished status read with no new event drops every flag the host was shown
    a_status_clears: assert property (
        @(posedge core_clk) disable iff (!rstn)
        rd_done_pulse && code_core == tof_status_pkg::ADDR_EVENT_STATUS
            && next_set == 16'h0000
            |=> (event_status_word & $past(word_hold)) == 16'h0000
    ) else $error("status flags survived a completed read");

    // trim completions started by the engine itself never reach the host
    a_trim_needs_host: assert property (
        @(posedge core_clk) disable iff (!rstn)
        evt_trim_done && !evt_trim_manual && !event_status_word[tof_status_pkg::BIT_TRIM_DONE]
            |=> !event_status_word[tof_status_pkg::BIT_TRIM_DONE]
    ) else $error("trim flag raised by an automatic calibration");

    // the power-up flag appears together with the end of the settle count
    a_power_flag_up: assert property (
        @(posedge core_clk) disable iff (!rstn)
        $rose(powered) |-> event_status_word[tof_status_pkg::BIT_POWER_UP]
    ) else $error("power-up flag missing when the port came up");

    // the port may not report ready ahead of the power-up flag
    a_port_waits: assert property (
        @(posedge core_clk) disable iff (!rstn)
        !powered |-> !port_ready
    ) else $error("port ready before power-up completed");

    // unused status bits read as zero
    a_reserved_zero: assert property (
        @(posedge core_clk) disable iff (!rstn)
        event_status_word[14:13] == 2'h0 && event_status_word[10:7] == 4'h0
            && event_status_word[5:4] == 2'h0 && event_status_word[1:0] == 2'h0
    ) else $error("reserved status bit set");

    // nothing but a result strobe may move a result register
    a_results_hold: assert property (
        @(posedge core_clk) disable iff (!rstn)
        !result_valid |=> $stable(upstream_pulse_ratios) && $stable(upstream_first_hit_integer)
            && $stable(upstream_first_hit_fraction)
    ) else $error("result register changed without a result strobe");

    // reset leaves every result register at zero; no disable here on purpose
    a_results_reset: assert property (
        @(posedge core_clk)
        !rstn |=> upstream_pulse_ratios == tof_status_pkg::RESET_WORD
            && upstream_first_hit_integer == tof_status_pkg::RESET_WORD
            && upstream_first_hit_fraction == tof_status_pkg::RESET_WORD
    ) else $error("result register not cleared by reset");

    // the integer count never uses its top bit
    a_int_limit: assert property (
        @(posedge core_clk) disable iff (!rstn)
        !upstream_first_hit_integer[15]
    ) else $error("integer hit count above its 15-bit limit");

    // the fraction is taken unchanged from the low half of the hit time
    a_frac_loads: assert property (
        @(posedge core_clk) disable iff (!rstn)
        result_valid |=> upstream_first_hit_fraction == $past(hit_time[15:0])
    ) else $error("fraction register did not take the hit remainder");

    // ------------------------------------------------------------
    // checks on the link side
    // ------------------------------------------------------------
    // the output stays released while the read code is still arriving
    a_miso_released: assert property (
        @(posedge spi_clk) disable iff (spi_csn)
        !in_data |-> spi_miso_oen
    ) else $error("serial output driven during the read code");

    // main scenarios worth seeing at least once
    c_port_up: cover property (@(posedge core_clk) disable iff (!rstn) $rose(port_ready));
    c_status_read: cover property (@(posedge core_clk) disable iff (!rstn)
        rd_done_pulse && code_core == tof_status_pkg::ADDR_EVENT_STATUS);
    c_ratio_clipped: cover property (@(posedge core_clk) disable iff (!rstn)
        result_valid && next_ratio_hi == tof_status_pkg::RATIO_MAX);
    c_trim_manual: cover property (@(posedge core_clk) disable iff (!rstn)
        evt_trim_done && evt_trim_manual);
    c_event_in_frame: cover property (@(posedge core_clk) disable iff (!rstn)
        rd_done_lvl && next_set != 16'h0000);
endmodule : tof_status_regs

// >>> dv/spi_host_model.sv
module spi_host_model (
    output logic spi_clk,
    output logic spi_csn,
    output logic spi_mosi,
    input wire logic spi_miso,
    input wire logic spi_miso_oen
);
    timeunit 1ns;
    timeprecision 100ps;

    // clock idles low and only toggles inside a frame
    initial begin
        // a rising select right after start puts the link logic in its idle state
        spi_clk = 1'b0;
        spi_csn = 1'b0;
        spi_mosi = 1'b0;
        #1;
        spi_csn = 1'b1;
    end

    // one read: code msb first on rises, word sampled on rises after device falls
    task automatic read_word(input logic [7:0] code, output logic [15:0] word);
        int i;
        word = 16'h0000;
        spi_csn = 1'b0;
        for (i = 0; i < 24; i++) begin
            spi_clk = 1'b0;
            spi_mosi = (i < 8) ? code[7 - i] : ~spi_mosi;
            #24;
            spi_clk = 1'b1;
            // a released line must not pass for data
            if (i >= 8) word = {word[14:0], spi_miso_oen ? 1'bx : spi_miso};
            #24;
        end
        spi_clk = 1'b0;
        #24;
        spi_csn = 1'b1;
        spi_mosi = ~spi_mosi;
        #48;
    endtask : read_word
endmodule : spi_host_model

// >>> dv/event_status_and_upstream_results_tb.sv
module event_status_and_upstream_results_tb;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {
        logic [15:0] wf;
        logic [15:0] ws;
        logic [15:0] lp;
        logic [31:0] ht;
    } row_type;
    logic core_clk;
    logic rstn = 1'b0;
    logic spi_clk, spi_csn, spi_mosi, spi_miso, spi_miso_oen, port_ready;
    logic [4:0] evt = 5'h00;
    logic manual = 1'b0;
    logic rv = 1'b0;
    row_type r = '0;
    logic [15:0] w;
    int miscompares = 0;
    int checks = 0;
    int cycles = 0;
    row_type rows [3] = '{'{16'h0064, 16'h0064, 16'h0190, 32'h1234ABCD},
        '{16'h012C, 16'h0064, 16'h0064, 32'hFFFFFFFF},
        '{16'h0001, 16'h00C8, 16'h03E8, 32'h7FFF0001}};
    int bits [5] = '{tof_status_pkg::BIT_WAIT_EXPIRED, tof_status_pkg::BIT_FLIGHT_DONE,
        tof_status_pkg::BIT_THERMAL_DONE, tof_status_pkg::BIT_TRIM_DONE,
        tof_status_pkg::BIT_SETUP_DONE};

    tof_status_regs u_dut (.core_clk(core_clk), .rstn(rstn), .spi_clk(spi_clk),
        .spi_csn(spi_csn), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
        .spi_miso_oen(spi_miso_oen), .evt_wait_expired(evt[0]), .evt_flight_done(evt[1]),
        .evt_thermal_done(evt[2]), .evt_trim_done(evt[3]), .evt_trim_manual(manual),
        .evt_setup_done(evt[4]), .result_valid(rv), .width_first(r.wf),
        .width_second(r.ws), .launch_period(r.lp), .hit_time(r.ht), .port_ready(port_ready));
    spi_host_model u_host (.spi_clk(spi_clk), .spi_csn(spi_csn), .spi_mosi(spi_mosi),
        .spi_miso(spi_miso), .spi_miso_oen(spi_miso_oen));

    // 200 MHz core clock
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // hang guard, well above the roughly 6200 cycles the run needs
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 40000) begin
            miscompares++;
            report_and_stop();
        end
    end

    // ratios truncate then saturate, integer clips at 15 bits
    function automatic logic [15:0] exp_word(row_type x, int k);
        logic [31:0] up;
        logic [31:0] lo;
        up = ({16'h0000, x.wf} << 7) / x.ws;
        lo = ({16'h0000, x.ws} << 8) / x.lp;
        if (up > 32'h000000FF) up = 32'h000000FF;
        if (lo > 32'h000000FF) lo = 32'h000000FF;
        if (k == 0) return {up[7:0], lo[7:0]};
        if (k == 1) return (x.ht[31:16] > 16'h7FFF) ? 16'h7FFF : x.ht[31:16];
        return x.ht[15:0];
    endfunction : exp_word

    task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t word %h expected %h", $time, got, exp);
        end
    endtask : check_word

    task automatic check_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t flag %b expected %b", $time, got, exp);
        end
    endtask : check_bit

    task automatic rd(input logic [7:0] code, input logic [15:0] exp);
        logic [15:0] got;
        u_host.read_word(code, got);
        check_word(got, exp);
    endtask : rd

    // one-cycle engine pulse, launched off the falling edge
    task automatic fire(input int k, input logic man);
        @(negedge core_clk);
        manual = man;
        evt[k] = 1'b1;
        @(negedge core_clk);
        evt = 5'h00;
    endtask : fire

    task automatic report_and_stop();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        int k;
        int j;
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        rstn = 1'b1;
        @(negedge core_clk);
        check_bit(port_ready, 1'b0);
        check_bit(spi_miso_oen, 1'b1);
        for (k = 0; k < 100 && port_ready !== 1'b1; k++) @(negedge core_clk);
        rd(tof_status_pkg::ADDR_EVENT_STATUS, 16'h0004);
        rd(tof_status_pkg::ADDR_EVENT_STATUS, 16'h0000);
        for (k = 0; k < 3; k++) rd(tof_status_pkg::ADDR_PULSE_RATIOS + 8'(k), 16'h0000);
        rd(8'h00, 16'h0000);
        // each row loads one result set, then every result register is read
        foreach (rows[k]) begin
            @(negedge core_clk);
            r = rows[k];
            rv = 1'b1;
            @(negedge core_clk);
            rv = 1'b0;
            for (j = 0; j < 3; j++) begin
                rd(tof_status_pkg::ADDR_PULSE_RATIOS + 8'(j), exp_word(rows[k], j));
            end
        end
        rd(8'h44, 16'h0000);
        rd(tof_status_pkg::ADDR_PULSE_RATIOS, exp_word(rows[2], 0));
        for (k = 0; k < 5; k++) begin
            fire(k, 1'b1);
            rd(tof_status_pkg::ADDR_EVENT_STATUS, 16'h0001 << bits[k]);
        end
        fire(3, 1'b0);
        rd(tof_status_pkg::ADDR_EVENT_STATUS, 16'h0000);
        // an event late in a status read must survive the clear
        fire(1, 1'b1);
        fork
            rd(tof_status_pkg::ADDR_EVENT_STATUS, 16'h1000);
            begin
                repeat (120) @(negedge core_clk);
                fire(0, 1'b1);
            end
        join
        rd(tof_status_pkg::ADDR_EVENT_STATUS, 16'h8000);
        report_and_stop();
    end
endmodule : event_status_and_upstream_results_tb
